// >>> rtl/ias_pkg.sv
/*
 * Shared constants and types of the indirect addressing and status block:
 * file addresses of the pointer ports and core registers, bit positions,
 * reset values, the bus register map and the ALU operation codes.
 * Assumes a 12-bit data memory address space and an 8-bit data path.
 */
`default_nettype none
package ias_pkg;

   localparam int ADDR_W   = 12;
   localparam int DATA_W   = 8;
   localparam int NUM_PTR  = 3;
   localparam int FLAG_W   = 5;
   localparam int APB_AW   = 8;

   // File addresses: pointer n owns PORT_BASE + PORT_STRIDE*n onward
   localparam logic [11:0] PORT_BASE    = 12'hFE0;
   localparam logic [11:0] PORT_STRIDE  = 12'h008;
   localparam logic [2:0]  OFS_NOCHG    = 3'h0;
   localparam logic [2:0]  OFS_POSTDEC  = 3'h1;
   localparam logic [2:0]  OFS_POSTINC  = 3'h2;
   localparam logic [2:0]  OFS_PREINC   = 3'h3;
   localparam logic [2:0]  OFS_PLUSW    = 3'h4;
   localparam logic [2:0]  OFS_PTR_LO   = 3'h5;
   localparam logic [2:0]  OFS_PTR_HI   = 3'h6;
   localparam logic [11:0] FILE_FLAGS   = 12'hFD8;
   localparam logic [11:0] FILE_WACC    = 12'hFD9;
   localparam logic [11:0] FILE_RESTART = 12'hFDA;

   // Arithmetic flag positions
   localparam int C_BIT  = 0;
   localparam int DC_BIT = 1;
   localparam int Z_BIT  = 2;
   localparam int OV_BIT = 3;
   localparam int N_BIT  = 4;

   // Restart cause flag positions
   localparam int BOR_BIT = 0;
   localparam int POR_BIT = 1;
   localparam int PD_BIT  = 2;
   localparam int TO_BIT  = 3;
   localparam int RI_BIT  = 4;

   localparam logic [4:0]  FLAGS_RST   = 5'h00;
   localparam logic [4:0]  RESTART_RST = 5'h1D;
   localparam logic [7:0]  WACC_RST    = 8'h00;
   localparam logic [11:0] PTR_RST     = 12'h000;

   // Bus register byte offsets
   localparam logic [7:0] REG_FLAGS   = 8'h00;
   localparam logic [7:0] REG_RESTART = 8'h04;
   localparam logic [7:0] REG_WACC    = 8'h08;
   localparam logic [7:0] REG_PTR0    = 8'h0C;
   localparam logic [7:0] REG_LAST    = 8'h20;

   typedef enum logic [2:0] {
      ALU_NONE, ALU_ADD, ALU_SUB, ALU_LOGIC, ALU_ROL, ALU_ROR
   } ias_alu_op_type;

   typedef enum logic [1:0] {TGT_MEM, TGT_NULL, TGT_REG} ias_target_type;

endpackage
`default_nettype wire

// >>> rtl/ias_core.sv
/*
 * Indirect addressing unit with the ALU flag register and restart cause
 * flags. The core presents one file access per cycle; port locations are
 * resolved through the pointers, internal registers are served here, a port
 * reached through a pointer is a null target and the rest goes to the data memory one cycle later. Software also reaches the
 * registers over APB. Assumes the memory answers reads combinationally in
 * the cycle mem_valid_out is high, and all inputs are synchronous.
 */
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module ias_core
   import ias_pkg::*;
(
   input  wire logic                 sys_clk_in,
   input  wire logic                 sys_rst_in,
   input  wire logic                 psel_in,
   input  wire logic                 penable_in,
   input  wire logic                 pwrite_in,
   input  wire logic [APB_AW-1:0]    paddr_in,
   input  wire logic [31:0]          pwdata_in,
   output logic      [31:0]          prdata_out,
   output logic                      pready_out,
   output logic                      pslverr_out,
   input  wire logic                 acc_valid_in,
   input  wire logic                 acc_write_in,
   input  wire logic [ADDR_W-1:0]    acc_addr_in,
   input  wire logic [DATA_W-1:0]    acc_wdata_in,
   input  wire ias_alu_op_type       alu_op_in,
   input  wire logic [DATA_W-1:0]    alu_a_in,
   input  wire logic [DATA_W-1:0]    alu_b_in,
   output logic                      acc_done_out,
   output logic      [DATA_W-1:0]    acc_rdata_out,
   output logic      [FLAG_W-1:0]    alu_flags_out,
   output logic                      mem_valid_out,
   output logic                      mem_write_out,
   output logic      [ADDR_W-1:0]    mem_addr_out,
   output logic      [DATA_W-1:0]    mem_wdata_out,
   input  wire logic [DATA_W-1:0]    mem_rdata_in,
   input  wire logic                 brownout_enable_fuse_in,
   input  wire logic                 power_on_event_in,
   input  wire logic                 brownout_event_in,
   input  wire logic                 watchdog_expiry_in,
   input  wire logic                 sleep_entry_in,
   input  wire logic                 watchdog_clear_in,
   input  wire logic                 reset_op_in
);

   typedef struct packed {
      logic [NUM_PTR-1:0][ADDR_W-1:0] data_pointer;
      logic [DATA_W-1:0]              working_accumulator;
      logic [FLAG_W-1:0]              alu_flags;
      logic [FLAG_W-1:0]              restart_source_flags;
      logic [31:0]                    prdata;
      logic                           pready;
      logic                           pslverr;
      logic                           mem_valid;
      logic                           mem_write;
      logic [ADDR_W-1:0]              mem_addr;
      logic [DATA_W-1:0]              mem_wdata;
      logic                           pend;
      logic                           pend_mem_rd;
      logic [DATA_W-1:0]              rd_hold;
      logic                           done;
      logic [DATA_W-1:0]              rdata;
   } ias_state_type;

   ias_state_type s;
   ias_state_type next_s;

   // Pointer group index and location of a file address, valid if in range
   function automatic logic in_ports(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] d;
      d = a - PORT_BASE;
      return (a >= PORT_BASE) && (d[11:3] < 9'(NUM_PTR));
   endfunction

   function automatic logic is_port(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] d;
      d = a - PORT_BASE;
      return in_ports(a) && (d[2:0] <= OFS_PLUSW);
   endfunction

   function automatic logic is_reg(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] d;
      d = a - PORT_BASE;
      return (a == FILE_FLAGS) || (a == FILE_WACC) || (a == FILE_RESTART) ||
             (in_ports(a) && ((d[2:0] == OFS_PTR_LO) || (d[2:0] == OFS_PTR_HI)));
   endfunction

   function automatic logic [DATA_W-1:0] reg_value(input ias_state_type st,
                                                   input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] d;
      logic [ADDR_W-1:0] p;
      d = a - PORT_BASE;
      p = st.data_pointer[d[4:3]];
      if (a == FILE_FLAGS) begin
         return {3'h0, st.alu_flags};
      end else if (a == FILE_WACC) begin
         return st.working_accumulator;
      end else if (a == FILE_RESTART) begin
         return {3'h0, st.restart_source_flags};
      end else if (d[2:0] == OFS_PTR_LO) begin
         return p[7:0];
      end else begin
         return {4'h0, p[11:8]};
      end
   endfunction

   always_comb begin
      logic [ADDR_W-1:0]  d;
      logic [1:0]         grp;
      logic [ADDR_W-1:0]  eff;
      logic [ADDR_W-1:0]  upd;
      logic               step;
      logic [ADDR_W-1:0]  wd;
      logic [1:0]         wgrp;
      ias_target_type     tgt;
      logic [DATA_W-1:0]  res;
      logic [FLAG_W-1:0]  fl;
      logic [8:0]         sum9;
      logic [4:0]         sum5;
      logic               apb_acc;
      logic [7:0]         rofs;
      logic [2:0]         ridx;
      d           = '0;
      grp         = '0;
      eff         = acc_addr_in;
      upd         = '0;
      step        = 1'b0;
      wd          = '0;
      wgrp        = '0;
      tgt         = TGT_MEM;
      res         = acc_wdata_in;
      fl          = s.alu_flags;
      sum9        = '0;
      sum5        = '0;
      rofs        = paddr_in - REG_PTR0;
      ridx        = rofs[5:3];
      apb_acc     = psel_in && penable_in;
      next_s      = s;

      // APB: one wait state, answer registered
      next_s.pready  = apb_acc && !s.pready;
      next_s.pslverr = 1'b0;
      next_s.prdata  = '0;
      if (apb_acc && !s.pready) begin
         next_s.pslverr = (paddr_in[1:0] != 2'h0) || (paddr_in > REG_LAST);
         if (paddr_in == REG_FLAGS) begin
            next_s.prdata = {27'h0, s.alu_flags};
         end else if (paddr_in == REG_RESTART) begin
            next_s.prdata = {27'h0, s.restart_source_flags};
         end else if (paddr_in == REG_WACC) begin
            next_s.prdata = {24'h0, s.working_accumulator};
         end else if (paddr_in >= REG_PTR0 && paddr_in <= REG_LAST) begin
            next_s.prdata = rofs[2] ? {28'h0, s.data_pointer[ridx[1:0]][11:8]}
                                    : {24'h0, s.data_pointer[ridx[1:0]][7:0]};
         end
      end
      if (apb_acc && s.pready && pwrite_in && !s.pslverr) begin
         if (paddr_in == REG_FLAGS) begin
            next_s.alu_flags = pwdata_in[4:0];
         end else if (paddr_in == REG_RESTART) begin
            next_s.restart_source_flags = pwdata_in[4:0];
         end else if (paddr_in == REG_WACC) begin
            next_s.working_accumulator = pwdata_in[7:0];
         end else if (paddr_in >= REG_PTR0 && paddr_in <= REG_LAST) begin
            if (rofs[2]) begin
               next_s.data_pointer[ridx[1:0]][11:8] = pwdata_in[3:0];
            end else begin
               next_s.data_pointer[ridx[1:0]][7:0] = pwdata_in[7:0];
            end
         end
      end

      // Resolve the core access through the pointer ports
      if (is_port(acc_addr_in)) begin
         d   = acc_addr_in - PORT_BASE;
         grp = d[4:3];
         eff = s.data_pointer[grp];
         unique case (d[2:0])
            OFS_POSTDEC: begin
               upd  = eff - 12'h001;
               step = 1'b1;
            end
            OFS_POSTINC: begin
               upd  = eff + 12'h001;
               step = 1'b1;
            end
            OFS_PREINC: begin
               upd  = eff + 12'h001;
               eff  = upd;
               step = 1'b1;
            end
            OFS_PLUSW: begin
               eff = eff + {{4{s.working_accumulator[7]}},
                            s.working_accumulator};
            end
            default: begin
            end
         endcase
      end
      if (is_port(eff)) begin
         tgt = TGT_NULL;
      end else if (is_reg(eff)) begin
         tgt = TGT_REG;
      end

      // Result and flags of a flag-updating write
      unique case (alu_op_in)
         ALU_ADD: begin
            sum9 = {1'b0, alu_a_in} + {1'b0, alu_b_in};
            sum5 = {1'b0, alu_a_in[3:0]} + {1'b0, alu_b_in[3:0]};
            res  = sum9[7:0];
            fl[OV_BIT] = (alu_a_in[7] == alu_b_in[7]) && (res[7] != alu_a_in[7]);
         end
         ALU_SUB: begin
            // Two's complement add: carry set means no borrow
            sum9 = {1'b0, alu_a_in} + {1'b0, ~alu_b_in} + 9'h001;
            sum5 = {1'b0, alu_a_in[3:0]} + {1'b0, ~alu_b_in[3:0]} + 5'h01;
            res  = sum9[7:0];
            fl[OV_BIT] = (alu_a_in[7] != alu_b_in[7]) && (res[7] != alu_a_in[7]);
         end
         ALU_LOGIC: begin
            res = alu_a_in;
         end
         ALU_ROL: begin
            res = {alu_a_in[6:0], s.alu_flags[C_BIT]};
            sum9[8] = alu_a_in[7];
            sum5[4] = alu_a_in[3];
         end
         ALU_ROR: begin
            res = {s.alu_flags[C_BIT], alu_a_in[7:1]};
            sum9[8] = alu_a_in[0];
            sum5[4] = alu_a_in[4];
         end
         ALU_NONE: begin
            res = acc_wdata_in;
         end
         default: begin
            res = acc_wdata_in;
         end
      endcase
      if (alu_op_in != ALU_NONE) begin
         fl[N_BIT] = res[7];
         fl[Z_BIT] = (res == 8'h00);
         if (alu_op_in != ALU_LOGIC) begin
            fl[C_BIT]  = sum9[8];
            fl[DC_BIT] = sum5[4];
         end
      end

      // Pipeline: memory strobe in cycle 1, answer in cycle 2
      next_s.mem_valid   = 1'b0;
      next_s.mem_write   = 1'b0;
      next_s.pend        = acc_valid_in;
      next_s.pend_mem_rd = 1'b0;
      next_s.rd_hold     = 8'h00;
      next_s.done        = s.pend;
      next_s.rdata       = s.pend_mem_rd ? mem_rdata_in : s.rd_hold;

      if (acc_valid_in) begin
         // Steps go to the pointer only; flags stay as they are
         if (step) begin
            next_s.data_pointer[grp] = upd;
         end
         if (acc_write_in) begin
            unique case (tgt)
               TGT_NULL: begin
                  // Nothing stored, flags left alone
               end
               TGT_MEM: begin
                  next_s.mem_valid = 1'b1;
                  next_s.mem_write = 1'b1;
                  next_s.mem_addr  = eff;
                  next_s.mem_wdata = res;
                  next_s.alu_flags = fl;
               end
               TGT_REG: begin
                  wd   = eff - PORT_BASE;
                  wgrp = wd[4:3];
                  if (eff == FILE_FLAGS) begin
                     // Flag-updating ops keep the computed flags
                     next_s.alu_flags = (alu_op_in == ALU_NONE) ? res[4:0] : fl;
                  end else begin
                     next_s.alu_flags = fl;
                     if (eff == FILE_WACC) begin
                        next_s.working_accumulator = res;
                     end else if (eff == FILE_RESTART) begin
                        next_s.restart_source_flags = res[4:0];
                     end else begin
                        if (wd[2:0] == OFS_PTR_LO) begin
                           next_s.data_pointer[wgrp] = {s.data_pointer[wgrp][11:8], res};
                        end else begin
                           next_s.data_pointer[wgrp] = {res[3:0], s.data_pointer[wgrp][7:0]};
                        end
                        // Same pointer stepped: drop the step, keep the write
                        if (step && wgrp != grp) begin
                           next_s.data_pointer[grp] = upd;
                        end
                     end
                  end
               end
               default: begin
               end
            endcase
         end else begin
            unique case (tgt)
               TGT_NULL: begin
                  next_s.rd_hold = 8'h00;
                  next_s.alu_flags[Z_BIT] = 1'b1;
               end
               TGT_REG: begin
                  next_s.rd_hold = reg_value(s, eff);
               end
               TGT_MEM: begin
                  next_s.mem_valid   = 1'b1;
                  next_s.mem_addr    = eff;
                  next_s.pend_mem_rd = 1'b1;
               end
               default: begin
               end
            endcase
         end
      end

      // Restart events last so they win over software writes
      if (watchdog_clear_in) begin
         next_s.restart_source_flags[TO_BIT] = 1'b1;
         next_s.restart_source_flags[PD_BIT] = 1'b1;
      end
      if (sleep_entry_in) begin
         next_s.restart_source_flags[TO_BIT] = 1'b1;
         next_s.restart_source_flags[PD_BIT] = 1'b0;
      end
      if (watchdog_expiry_in) begin
         next_s.restart_source_flags[TO_BIT] = 1'b0;
      end
      if (reset_op_in) begin
         next_s.restart_source_flags[RI_BIT] = 1'b0;
      end
      if (power_on_event_in) begin
         next_s.restart_source_flags = RESTART_RST;
         next_s.restart_source_flags[POR_BIT] = 1'b0;
         // Without the fuse the brown-out flag is simply left as it was
         next_s.restart_source_flags[BOR_BIT] = brownout_enable_fuse_in ? 1'b1
                                                : s.restart_source_flags[BOR_BIT];
      end
      if (brownout_event_in && brownout_enable_fuse_in) begin
         next_s.restart_source_flags[BOR_BIT] = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         s                      <= '0;
         s.data_pointer         <= {NUM_PTR{PTR_RST}};
         s.working_accumulator  <= WACC_RST;
         s.alu_flags            <= FLAGS_RST;
         s.restart_source_flags <= RESTART_RST;
      end else begin
         s <= next_s;
      end
   end

   assign prdata_out    = s.prdata;
   assign pready_out    = s.pready;
   assign pslverr_out   = s.pslverr;
   assign acc_done_out  = s.done;
   assign acc_rdata_out = s.rdata;
   assign alu_flags_out = s.alu_flags;
   assign mem_valid_out = s.mem_valid;
   assign mem_write_out = s.mem_write;
   assign mem_addr_out  = s.mem_addr;
   assign mem_wdata_out = s.mem_wdata;

endmodule
`default_nettype wire

// >>> tb/ias_mem_model.sv
/* Data memory behind the indirect addressing block.
   Assumes reads are answered in the cycle the strobe is high. */
`timescale 1ns/10ps
`default_nettype none
module ias_mem_model (
   input  wire logic        clk_in,
   input  wire logic        valid_in,
   input  wire logic        write_in,
   input  wire logic [11:0] addr_in,
   input  wire logic [7:0]  wdata_in,
   output logic      [7:0]  rdata_out
);
   logic [7:0] mem [4096];
   logic [7:0] idle = 8'hA5;
   always @(posedge clk_in) begin
      idle <= idle + 8'h3B;
      if (valid_in && write_in) begin
         mem[addr_in] <= wdata_in;
      end
   end
   // Idle pattern moves every cycle so stale data never looks valid
   assign rdata_out = valid_in ? mem[addr_in] : idle;
endmodule
`default_nettype wire

// >>> tb/ias_core_monitor.sv
/* Port checker for ias_core.
   Assumes one clock and the synchronous active-high reset. */
`timescale 1ns/10ps
`default_nettype none
module ias_core_monitor
   import ias_pkg::*;
(
   input wire logic              sys_clk_in,
   input wire logic              sys_rst_in,
   input wire logic              psel_in,
   input wire logic              penable_in,
   input wire logic [APB_AW-1:0] paddr_in,
   input wire logic [31:0]       prdata_out,
   input wire logic              pready_out,
   input wire logic              pslverr_out,
   input wire logic              acc_valid_in,
   input wire logic              acc_write_in,
   input wire logic [ADDR_W-1:0] acc_addr_in,
   input wire logic [DATA_W-1:0] acc_wdata_in,
   input wire ias_alu_op_type    alu_op_in,
   input wire logic              acc_done_out,
   input wire logic [DATA_W-1:0] acc_rdata_out,
   input wire logic [FLAG_W-1:0] alu_flags_out,
   input wire logic              mem_valid_out,
   input wire logic              mem_write_out,
   input wire logic [ADDR_W-1:0] mem_addr_out,
   input wire logic [DATA_W-1:0] mem_wdata_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);
   a_done_two_late: assert property (acc_valid_in |-> ##2 acc_done_out)
      else $error("access done not two cycles late");
   a_plain_addr_pass: assert property (acc_valid_in && acc_addr_in < 12'hF00
      |=> mem_valid_out && mem_addr_out == $past(acc_addr_in)) else $error("plain address lost");
   a_wdata_pass: assert property (acc_valid_in && acc_write_in && alu_op_in == ALU_NONE
      && acc_addr_in < 12'hF00 |=> mem_write_out && mem_wdata_out == $past(acc_wdata_in))
      else $error("write data lost");
   a_mem_has_cause: assert property (mem_valid_out |-> $past(acc_valid_in))
      else $error("memory strobe without request");
   a_write_rdata_zero: assert property (acc_valid_in && acc_write_in
      |-> ##2 acc_rdata_out == 8'h00) else $error("write returned data");
   a_pready_one_wait: assert property (psel_in && penable_in && !pready_out
      |=> pready_out) else $error("bus answer late");
   a_pready_pulse: assert property (pready_out |=> !pready_out)
      else $error("ready held too long");
   a_err_with_ready: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
   a_flags_upper: assert property (pready_out && paddr_in == REG_FLAGS
      |-> prdata_out[31:5] == 27'h0) else $error("flag upper bits set");
   a_reset_quiet: assert property ($fell(sys_rst_in) |-> alu_flags_out == FLAGS_RST
      && !acc_done_out && !mem_valid_out) else $error("outputs busy after reset");
   c_bus_error: cover property (pslverr_out);
   c_mem_write: cover property (mem_valid_out && mem_write_out);
   c_port_read: cover property (acc_done_out && !mem_valid_out && acc_rdata_out == 8'h00);
endmodule
bind ias_core ias_core_monitor u_mon (.*);
`default_nettype wire

// >>> tb/tb_ias_core.sv
/* Self-checking bench for ias_core with a data memory model.
   Assumes APB answers with one wait state and the fixed seed. */
`timescale 1ns/10ps
`default_nettype none
module tb_ias_core
   import ias_pkg::*;
;
   logic sys_clk_in, sys_rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
   logic acc_valid_in, acc_write_in, acc_done_out, mem_valid_out, mem_write_out;
   logic brownout_enable_fuse_in, err, sv, sdn;
   logic [7:0] paddr_in, acc_wdata_in, alu_a_in, alu_b_in, acc_rdata_out, mem_wdata_out;
   logic [7:0] mem_rdata_in, sd, sr, d1, d2;
   logic [31:0] pwdata_in, prdata_out, rd32;
   logic [11:0] acc_addr_in, mem_addr_out, sa, p;
   logic [4:0] alu_flags_out, gf, ef;
   logic [5:0] ev;
   logic [15:0] tbl [9] = '{16'h131B, 16'h141F, 16'h1217, 16'h1507, 16'h1106, 16'h0106,
                            16'h101D, 16'h111C, 16'h001C};
   ias_alu_op_type alu_op_in;
   int error_cnt = 0, samples_checked = 0, cyc = 0;
   integer seed = 32'hbf8ce339;
   ias_core DUT (.*, .power_on_event_in(ev[0]), .brownout_event_in(ev[1]),
      .watchdog_expiry_in(ev[2]), .sleep_entry_in(ev[3]), .watchdog_clear_in(ev[4]),
      .reset_op_in(ev[5]));
   ias_mem_model u_mem (.clk_in(sys_clk_in), .valid_in(mem_valid_out), .write_in(mem_write_out),
      .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in));
   initial begin
      sys_clk_in = 0;
      forever #20 sys_clk_in = ~sys_clk_in;
   end
   task automatic chk(input logic [31:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("checked %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         close_out();
      end
   end
   function automatic logic [11:0] pa(input int n, input logic [2:0] o);
      return 12'(PORT_BASE + PORT_STRIDE * n + o);
   endfunction
   function automatic logic [12:0] alu_exp(input ias_alu_op_type o, input logic [7:0] a, b,
                                           input logic [4:0] f);
      logic [7:0] bb, r;
      logic [8:0] s;
      logic [4:0] h, n;
      n = f;
      bb = (o == ALU_SUB) ? ~b : b;
      s = {1'b0, a} + {1'b0, bb} + {8'h00, o == ALU_SUB};
      h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, o == ALU_SUB};
      r = (o == ALU_ADD || o == ALU_SUB) ? s[7:0] : a;
      if (o == ALU_ADD || o == ALU_SUB) begin
         n[C_BIT] = s[8];
         n[DC_BIT] = h[4];
         n[OV_BIT] = (a[7] == bb[7]) && (r[7] != a[7]);
      end else if (o == ALU_ROL) begin
         r = {a[6:0], f[C_BIT]};
         n[C_BIT] = a[7];
         n[DC_BIT] = a[3];
      end else if (o == ALU_ROR) begin
         r = {f[C_BIT], a[7:1]};
         n[C_BIT] = a[0];
         n[DC_BIT] = a[4];
      end
      n[N_BIT] = r[7];
      n[Z_BIT] = (r == 8'h00);
      return {n, r};
   endfunction
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      psel_in <= 1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge sys_clk_in);
      penable_in <= 1;
      do @(posedge sys_clk_in); while (pready_out !== 1'b1);
      rd32 = prdata_out;
      err = pslverr_out;
      psel_in <= 0;
      penable_in <= 0;
   endtask
   task automatic core(input logic w, input logic [11:0] a, input ias_alu_op_type o,
                       input logic [7:0] d, x, y);
      @(posedge sys_clk_in);
      acc_valid_in <= 1;
      acc_write_in <= w;
      acc_addr_in <= a;
      acc_wdata_in <= d;
      alu_op_in <= o;
      alu_a_in <= x;
      alu_b_in <= y;
      @(posedge sys_clk_in);
      acc_valid_in <= 0;
      @(posedge sys_clk_in);
      {sv, sa, sd} = {mem_valid_out, mem_addr_out, mem_wdata_out};
      @(posedge sys_clk_in);
      {sdn, sr} = {acc_done_out, acc_rdata_out};
      @(posedge sys_clk_in);
      gf = alu_flags_out;
      chk(sdn, 1);
   endtask
   task automatic setptr(input int n, input logic [11:0] v);
      apb(1, 8'(REG_PTR0 + 8 * n), {24'h0, v[7:0]});
      apb(1, 8'(REG_PTR0 + 8 * n + 4), {28'h0, v[11:8]});
   endtask
   task automatic rdptr(input int n);
      apb(0, 8'(REG_PTR0 + 8 * n), 0);
      p[7:0] = rd32[7:0];
      apb(0, 8'(REG_PTR0 + 8 * n + 4), 0);
      p[11:8] = rd32[3:0];
   endtask
   task automatic alu_case(input ias_alu_op_type o, input logic [7:0] a, b, input int i);
      logic [12:0] x;
      x = alu_exp(o, a, b, ef);
      core(1, pa(2, OFS_POSTINC), o, 8'h00, a, b);
      chk({sa, sd}, {12'(12'h200 + i), x[7:0]});
      chk(gf, x[12:8]);
      ef = x[12:8];
   endtask
   initial begin
      {sys_rst_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = {1'b1, 43'h0};
      {acc_valid_in, acc_write_in, acc_addr_in, acc_wdata_in, alu_a_in, alu_b_in} = 38'h0;
      alu_op_in = ALU_NONE;
      {brownout_enable_fuse_in, ev} = 7'h40;
      repeat (12) @(posedge sys_clk_in);
      sys_rst_in <= 0;
      apb(0, REG_FLAGS, 0);
      chk(rd32, 0);
      apb(0, REG_RESTART, 0);
      chk(rd32, RESTART_RST);
      apb(1, 8'h24, 32'hFF);
      chk(err, 1);
      apb(0, 8'h02, 0);
      chk({err, rd32[30:0]}, 32'h80000000);
      $display("test registers done");
      d1 = 8'($random(seed));
      d2 = 8'($random(seed));
      core(1, 12'h300, ALU_NONE, d2, 0, 0);
      core(0, 12'h300, ALU_NONE, 0, 0, 0);
      chk(sr, d2);
      setptr(0, 12'h0FF);
      core(1, pa(0, OFS_POSTINC), ALU_NONE, d1, 0, 0);
      chk(sa, 12'h0FF);
      rdptr(0);
      chk(p, 12'h100);
      core(1, pa(0, OFS_PREINC), ALU_NONE, d2, 0, 0);
      chk(sa, 12'h101);
      core(0, pa(0, OFS_POSTDEC), ALU_NONE, 0, 0, 0);
      chk({sa, sr}, {12'h101, d2});
      apb(1, REG_WACC, 32'hFF);
      core(0, pa(0, OFS_PLUSW), ALU_NONE, 0, 0, 0);
      chk({sa, sr}, {12'h0FF, d1});
      core(0, pa(0, OFS_NOCHG), ALU_NONE, 0, 0, 0);
      chk(sa, 12'h100);
      rdptr(0);
      chk(p, 12'h100);
      apb(1, REG_FLAGS, 0);
      setptr(0, 12'h001);
      core(1, pa(0, OFS_POSTDEC), ALU_NONE, d1, 0, 0);
      chk(gf, 5'h00);
      core(1, pa(0, OFS_POSTDEC), ALU_NONE, d2, 0, 0);
      rdptr(0);
      chk(p, 12'hFFF);
      apb(1, REG_WACC, 32'h01);
      core(0, pa(0, OFS_PLUSW), ALU_NONE, 0, 0, 0);
      chk({sa, sr}, {12'h000, d2});
      $display("test pointers done");
      setptr(1, pa(0, OFS_NOCHG));
      core(0, pa(1, OFS_NOCHG), ALU_NONE, 0, 0, 0);
      chk({sv, sr, gf[Z_BIT]}, 10'h001);
      ef = gf;
      core(1, pa(1, OFS_NOCHG), ALU_ADD, 0, 8'h80, 8'h80);
      chk({sv, gf}, {1'b0, ef});
      setptr(0, pa(0, OFS_PTR_LO));
      core(1, pa(0, OFS_POSTINC), ALU_NONE, 8'h34, 0, 0);
      rdptr(0);
      chk(p, 12'hF34);
      core(0, pa(0, OFS_PTR_LO), ALU_NONE, 0, 0, 0);
      chk(sr, 8'h34);
      core(1, FILE_FLAGS, ALU_LOGIC, 0, 0, 0);
      chk(gf, 5'h04);
      core(1, FILE_FLAGS, ALU_NONE, 8'hFF, 0, 0);
      apb(0, REG_FLAGS, 0);
      chk(rd32, 32'h1F);
      core(1, FILE_FLAGS, ALU_ADD, 0, 8'h01, 8'h01);
      chk(gf, 5'h00);
      $display("test flags done");
      setptr(2, 12'h200);
      ef = gf;
      alu_case(ALU_ADD, 8'h7F, 8'h01, 0);
      alu_case(ALU_SUB, 8'h80, 8'h01, 1);
      alu_case(ALU_SUB, 8'h10, 8'h10, 2);
      for (int i = 3; i < 40; i++) begin
         alu_case(ias_alu_op_type'(3'(1 + {$random(seed)} % 5)), 8'($random(seed)),
                  8'($random(seed)), i);
      end
      $display("test alu done");
      apb(1, REG_RESTART, 32'h1F);
      foreach (tbl[i]) begin
         @(posedge sys_clk_in);
         brownout_enable_fuse_in <= tbl[i][12];
         ev <= 6'(1 << tbl[i][11:8]);
         @(posedge sys_clk_in);
         ev <= 6'h00;
         apb(0, REG_RESTART, 0);
         chk(rd32, {24'h0, tbl[i][7:0]});
      end
      $display("test restart done");
      close_out();
   end
endmodule
`default_nettype wire
